/* File: pkg/iep_pkg.sv */
package iep_pkg;
  // ==========================================================
  // register map (word indices from address bits 3:2, one 32-bit word each)
  localparam logic [1:0] IEP_IDX_EN3 = 2'h0;
  localparam logic [1:0] IEP_IDX_EN4 = 2'h1;
  localparam logic [1:0] IEP_IDX_PRI0 = 2'h2;
  localparam logic [1:0] IEP_IDX_PRI1 = 2'h3;
  localparam int IEP_IDX_LSB = 2;
  localparam int IEP_IDX_MSB = 3;
  // ==========================================================
  // implemented bits and power-on values
  localparam logic [15:0] IEP_EN3_MASK = 16'h39ff;
  localparam logic [15:0] IEP_EN4_MASK = 16'h00f6;
  localparam logic [15:0] IEP_PRI_MASK = 16'h7777;
  localparam logic [15:0] IEP_EN_RST = 16'h0000;
  localparam logic [15:0] IEP_PRI_RST = 16'h4444;
  localparam logic [2:0] IEP_PRI_OFF = 3'h0;
  localparam logic [2:0] IEP_PRI_TOP = 3'h7;
  localparam int IEP_FIELD_W = 3;
  localparam int IEP_FIELD_STRIDE = 4;
  localparam int IEP_NPRI = 8;
  // ==========================================================
  // block state
  typedef struct packed {
    logic [15:0] en3;
    logic [15:0] en4;
    logic [15:0] pri0;
    logic [15:0] pri1;
    logic aw;
    logic [1:0] ai;
    logic [31:0] rdata;
    logic [15:0] req3;
    logic [15:0] req4;
    logic [7:0] preq;
    logic [23:0] plvl;
  } iep_state_t;
endpackage

/* File: hw/iep_regs.sv */
// Notes on behaviour
// - a source's request passes only while its enable bit is 1.
// - each of the 8 priority sources has a 3-bit priority field; 111 is level 7, highest.
// - field 001 is level 1; values 2 to 6 map to matching levels.
// - field 000 disables the source whatever its enable bit says.
// - unassigned bits ignore writes and read as zero.
// - reset clears enables and loads every priority field with 100.
// - enable register 4 holds bits 7,6,5,4,2,1 only.
// - dma channels 7 and 6 done enables sit at bits 5 and 4.
// - priority register 0 holds timer1, compare1, capture1, ext irq0.
// - priority register 1 holds timer2, compare2, capture2, dma0.
// - bits 15, 11, 7 and 3 of priority registers read as zero.
// - enable register 3 holds bits 13,12,11,8 and 7 to 0.
module iep_regs #(
  parameter int AW = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] en3_flag,
  input wire logic [15:0] en4_flag,
  input wire logic [7:0] pri_flag,
  input wire logic [7:0] pri_src_en,
  output logic [15:0] en3_req,
  output logic [15:0] en4_req,
  output logic [7:0] pri_req,
  output logic [23:0] pri_lvl,
  output logic [15:0] en3_val,
  output logic [15:0] en4_val
);
  // ==========================================================
  // state
  iep_pkg::iep_state_t r;
  iep_pkg::iep_state_t n;
  logic take;
  logic hit;
  logic [1:0] idx;
  logic [31:0] pri_all;
  // settled register contents, for checks that compare in the same cycle
  logic [31:0] pri_now;

  assign idx = haddr[iep_pkg::IEP_IDX_MSB:iep_pkg::IEP_IDX_LSB];
  // only word slots 0..3 decode; everything else answers OKAY with zero
  assign hit = (haddr[AW-1:iep_pkg::IEP_IDX_MSB+1] == '0);
  assign take = hsel && htrans[1] && hready;
  assign pri_all = {n.pri1, n.pri0};
  assign pri_now = {r.pri1, r.pri0};

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    n.aw = take && hwrite && hit;
    n.ai = idx;
    if (r.aw) begin
      case (r.ai)
        iep_pkg::IEP_IDX_EN3: n.en3 = hwdata[15:0] & iep_pkg::IEP_EN3_MASK;
        iep_pkg::IEP_IDX_EN4: n.en4 = hwdata[15:0] & iep_pkg::IEP_EN4_MASK;
        iep_pkg::IEP_IDX_PRI0: n.pri0 = hwdata[15:0] & iep_pkg::IEP_PRI_MASK;
        iep_pkg::IEP_IDX_PRI1: n.pri1 = hwdata[15:0] & iep_pkg::IEP_PRI_MASK;
        default: n.en3 = r.en3;
      endcase
    end
    // read data is taken from the post-write value so a read right
    // behind a write to the same word sees the new contents
    n.rdata = '0;
    if (take && !hwrite && hit) begin
      case (idx)
        iep_pkg::IEP_IDX_EN3: n.rdata = {16'h0000, n.en3};
        iep_pkg::IEP_IDX_EN4: n.rdata = {16'h0000, n.en4};
        iep_pkg::IEP_IDX_PRI0: n.rdata = {16'h0000, n.pri0};
        iep_pkg::IEP_IDX_PRI1: n.rdata = {16'h0000, n.pri1};
        default: n.rdata = '0;
      endcase
    end
    n.req3 = en3_flag & r.en3;
    n.req4 = en4_flag & r.en4;
    for (int k = 0; k < iep_pkg::IEP_NPRI; k++) begin
      n.plvl[k*iep_pkg::IEP_FIELD_W +: iep_pkg::IEP_FIELD_W] =
        pri_all[k*iep_pkg::IEP_FIELD_STRIDE +: iep_pkg::IEP_FIELD_W];
      n.preq[k] = pri_flag[k] && pri_src_en[k] &&
        (pri_all[k*iep_pkg::IEP_FIELD_STRIDE +: iep_pkg::IEP_FIELD_W] != iep_pkg::IEP_PRI_OFF);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.en3 <= iep_pkg::IEP_EN_RST;
      r.en4 <= iep_pkg::IEP_EN_RST;
      r.pri0 <= iep_pkg::IEP_PRI_RST;
      r.pri1 <= iep_pkg::IEP_PRI_RST;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign en3_req = r.req3;
  assign en4_req = r.req4;
  assign pri_req = r.preq;
  assign pri_lvl = r.plvl;
  assign en3_val = r.en3;
  assign en4_val = r.en4;

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_wr_addr(logic [1:0] i);
    take && hwrite && hit && idx == i;
  endsequence

  sequence s_wr_data;
    1'b1;
  endsequence

  sequence s_rd_addr(logic [1:0] i);
    take && !hwrite && hit && idx == i;
  endsequence

  AST_EN_GATE: assert property (
    ((en3_flag & ~r.en3) != 0) |=> ((en3_req & ~$past(r.en3)) == 0))
    else $error("request passed with enable clear");

  AST_TOP_LEVEL: assert property (
    (r.pri0[14:12] == iep_pkg::IEP_PRI_TOP) |-> (pri_lvl[11:9] == 3'h7))
    else $error("field 111 not shown as level 7");

  AST_LEVEL_MAP: assert property (
    (r.pri1[2:0] == 3'h1) |-> (pri_lvl[14:12] == 3'h1))
    else $error("field 001 not shown as level 1");

  AST_OFF_BLOCKS: assert property (
    (r.pri0[6:4] == iep_pkg::IEP_PRI_OFF) |-> !pri_req[1])
    else $error("disabled source still requests");

  AST_RSVD_ZERO: assert property (
    (take && !hwrite && !hit) |=> (hrdata == 32'h0))
    else $error("unmapped read not zero");

  AST_RESET_VAL: assert property (@(posedge hclk) disable iff (1'b0)
    $rose(hresetn) |-> (r.en3 == 16'h0) && (r.en4 == 16'h0) && (r.pri0 == 16'h4444) && (r.pri1 == 16'h4444))
    else $error("reset values wrong");

  AST_EN4_WRITE: assert property (
    s_wr_addr(iep_pkg::IEP_IDX_EN4) ##1 s_wr_data |=> (r.en4 == ($past(hwdata[15:0]) & 16'h00f6)))
    else $error("enable register 4 write wrong");

  AST_DMA_BITS: assert property (
    (en4_flag[5] && r.en4[5]) |=> en4_req[5])
    else $error("dma channel 7 request lost");

  AST_PRI0_MAP: assert property (
    s_wr_addr(iep_pkg::IEP_IDX_PRI0) ##1 s_wr_data |=> (pri_lvl[11:9] == $past(hwdata[14:12])))
    else $error("timer1 field misplaced");

  AST_PRI1_MAP: assert property (
    s_wr_addr(iep_pkg::IEP_IDX_PRI1) ##1 s_wr_data |=> (pri_lvl[14:12] == $past(hwdata[2:0])))
    else $error("dma channel 0 field misplaced");

  AST_PRI_GAPS: assert property (
    ((r.pri0 | r.pri1) & 16'h8888) == 16'h0)
    else $error("priority gap bit set");

  AST_EN3_BITS: assert property (
    (r.en3 & 16'hc600) == 16'h0)
    else $error("enable register 3 reserved bit set");

  AST_REQ_COND: assert property (
    pri_req[7] |-> $past(pri_flag[7] && pri_src_en[7]) && (r.pri1[14:12] != 3'h0))
    else $error("request without cause");

  // ==========================================================
  // bus answers
  AST_READY_ONE: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  AST_RD_UPPER_ZERO: assert property (
    hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  AST_IDLE_RD_ZERO: assert property (
    !(take && !hwrite && hit) |=> (hrdata == 32'h0))
    else $error("read data shown without a read");

  AST_RD_EN3: assert property (
    s_rd_addr(iep_pkg::IEP_IDX_EN3) |=> (hrdata == {16'h0000, r.en3}))
    else $error("enable register 3 read wrong");

  AST_RD_EN4: assert property (
    s_rd_addr(iep_pkg::IEP_IDX_EN4) |=> (hrdata == {16'h0000, r.en4}))
    else $error("enable register 4 read wrong");

  AST_RD_PRI0: assert property (
    s_rd_addr(iep_pkg::IEP_IDX_PRI0) |=> (hrdata == {16'h0000, r.pri0}))
    else $error("priority register 0 read wrong");

  AST_RD_PRI1: assert property (
    s_rd_addr(iep_pkg::IEP_IDX_PRI1) |=> (hrdata == {16'h0000, r.pri1}))
    else $error("priority register 1 read wrong");

  // ==========================================================
  // register writes
  AST_EN3_WRITE: assert property (
    s_wr_addr(iep_pkg::IEP_IDX_EN3) ##1 s_wr_data |=> (r.en3 == ($past(hwdata[15:0]) & iep_pkg::IEP_EN3_MASK)))
    else $error("enable register 3 write wrong");

  AST_PRI0_WRITE: assert property (
    s_wr_addr(iep_pkg::IEP_IDX_PRI0) ##1 s_wr_data |=> (r.pri0 == ($past(hwdata[15:0]) & iep_pkg::IEP_PRI_MASK)))
    else $error("priority register 0 write wrong");

  AST_PRI1_WRITE: assert property (
    s_wr_addr(iep_pkg::IEP_IDX_PRI1) ##1 s_wr_data |=> (r.pri1 == ($past(hwdata[15:0]) & iep_pkg::IEP_PRI_MASK)))
    else $error("priority register 1 write wrong");

  // registers move only at the end of an accepted write data phase
  AST_HOLD: assert property (
    !r.aw |=> $stable({r.en3, r.en4, r.pri0, r.pri1}))
    else $error("register changed without a write");

  AST_UNMAPPED_WR: assert property (
    (take && hwrite && !hit) |=> !r.aw)
    else $error("unmapped write accepted");

  AST_EN4_RSVD: assert property (
    (r.en4 & ~iep_pkg::IEP_EN4_MASK) == 16'h0000)
    else $error("enable register 4 reserved bit set");

  // ==========================================================
  // request paths
  AST_EN3_REQ: assert property (
    1'b1 |=> (en3_req == $past(en3_flag & r.en3)))
    else $error("enable register 3 request wrong");

  AST_EN4_REQ: assert property (
    1'b1 |=> (en4_req == $past(en4_flag & r.en4)))
    else $error("enable register 4 request wrong");

  AST_DMA_OFF: assert property (
    !r.en4[4] |=> !en4_req[4])
    else $error("dma channel 6 request passed while disabled");

  AST_UART_ERR: assert property (
    (en4_flag[1] && r.en4[1]) |=> en4_req[1])
    else $error("uart1 error request lost");

  AST_CAN_TX: assert property (
    (en4_flag[7] && r.en4[7]) |=> en4_req[7])
    else $error("can2 transmit request lost");

  AST_DMA6_BIT: assert property (
    (en4_flag[4] && r.en4[4]) |=> en4_req[4])
    else $error("dma channel 6 request lost");

  AST_DMA5_BIT: assert property (
    (en3_flag[13] && r.en3[13]) |=> en3_req[13])
    else $error("dma channel 5 request lost");

  AST_EN3_GAP_REQ: assert property (
    (en3_req & ~iep_pkg::IEP_EN3_MASK) == 16'h0000)
    else $error("request on unused enable 3 bit");

  AST_EN4_GAP_REQ: assert property (
    (en4_req & ~iep_pkg::IEP_EN4_MASK) == 16'h0000)
    else $error("request on unused enable 4 bit");

  AST_RESET_OUT: assert property (@(posedge hclk) disable iff (1'b0)
    $rose(hresetn) |-> (en3_req == 16'h0) && (en4_req == 16'h0) && (pri_req == 8'h0) && (hrdata == 32'h0))
    else $error("outputs not quiet after reset");

  AST_MID_FIELD: assert property (
    (r.pri0[10:8] == 3'h5) |-> (pri_lvl[8:6] == 3'h5))
    else $error("field 101 not shown as level 5");

  // ==========================================================
  // per source level and request; the first cycle after reset is
  // skipped because the level outputs still hold their cleared value
  for (genvar k = 0; k < iep_pkg::IEP_NPRI; k++) begin : g_src
    AST_SRC_LEVEL: assert property (
      $past(hresetn) |->
        (pri_lvl[k*iep_pkg::IEP_FIELD_W +: iep_pkg::IEP_FIELD_W] ==
         pri_now[k*iep_pkg::IEP_FIELD_STRIDE +: iep_pkg::IEP_FIELD_W]))
      else $error("source level differs from its field");

    AST_SRC_REQ: assert property (
      $past(hresetn) |->
        (pri_req[k] == ($past(pri_flag[k] && pri_src_en[k]) &&
         (pri_now[k*iep_pkg::IEP_FIELD_STRIDE +: iep_pkg::IEP_FIELD_W] != iep_pkg::IEP_PRI_OFF))))
      else $error("source request differs from its cause");

    AST_SRC_OFF: assert property (
      (pri_now[k*iep_pkg::IEP_FIELD_STRIDE +: iep_pkg::IEP_FIELD_W] == iep_pkg::IEP_PRI_OFF) |-> !pri_req[k])
      else $error("source with field 000 still requests");
  end
endmodule

/* File: tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_dp = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] en3_flag = 16'h0, en4_flag = 16'h0, en3_req, en4_req, en3_val, en4_val;
  logic [7:0] pri_flag = 8'h0, pri_src_en = 8'h0, pri_req;
  logic [23:0] pri_lvl;
  logic [31:0] exp_q[$];
  logic [15:0] msk[4] = '{16'h39ff, 16'h00f6, 16'h7777, 16'h7777};
  int n_fail = 0;
  int comparisons = 0;

  iep_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .en3_flag(en3_flag), .en4_flag(en4_flag), .pri_flag(pri_flag),
    .pri_src_en(pri_src_en), .en3_req(en3_req), .en4_req(en4_req), .pri_req(pri_req),
    .pri_lvl(pri_lvl), .en3_val(en3_val), .en4_val(en4_val));

  always #5 hclk = ~hclk;

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bus ready sampled at each rising edge; a stuck slave ends the run
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        n_fail++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic w, input int idx, input logic [31:0] d, input logic [15:0] e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 12'(4 * idx);
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= ~w;
    if (!w) exp_q.push_back({16'h0, e});
    wait_rdy();
    rd_dp <= 1'b0;
  endtask

  // read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_dp && exp_q.size() > 0) check(hrdata, exp_q.pop_front());
  end

  initial begin
    logic [31:0] r;
    int i;
    r = $urandom(32'h532137dd);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 4; i++) xfer(1'b0, i, 32'h0, i < 2 ? 16'h0000 : 16'h4444);
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, i, 32'hffffffff, 16'h0);
      xfer(1'b0, i, 32'h0, msk[i]);
    end
    xfer(1'b1, 4, 32'h0, 16'h0);
    xfer(1'b0, 4, 32'h0, 16'h0);
    xfer(1'b0, 0, 32'h0, msk[0]);
    repeat (8) begin
      r = $urandom;
      i = $urandom_range(3);
      xfer(1'b1, i, r, 16'h0);
      xfer(1'b0, i, 32'h0, r[15:0] & msk[i]);
    end
    xfer(1'b1, 2, 32'h3210, 16'h0);
    xfer(1'b1, 3, 32'h7654, 16'h0);
    for (i = 0; i < 6; i++) begin
      r = (i < 3) ? 32'h0 : 32'hffff;
      xfer(1'b1, 0, r, 16'h0);
      xfer(1'b1, 1, r, 16'h0);
      en3_flag <= 16'($urandom);
      en4_flag <= 16'($urandom);
      pri_flag <= 8'($urandom);
      pri_src_en <= 8'($urandom);
      repeat (4) @(posedge hclk);
      @(negedge hclk);
      check(32'(en3_val), 32'(r[15:0] & msk[0]));
      check(32'(en4_val), 32'(r[15:0] & msk[1]));
      check(32'(hresp), 32'h0);
      check(32'(en3_req), 32'(en3_flag & r[15:0] & msk[0]));
      check(32'(en4_req), 32'(en4_flag & r[15:0] & msk[1]));
      check(32'(pri_req), 32'(pri_flag & pri_src_en & 8'hfe));
      check(32'(pri_lvl), 32'h00fac688);
    end
    test_done();
  end
endmodule
